// >>> design/usbu_pkg.sv
// Purpose: Shared constants for the USB serial bridge core.
// Assumes: 250 MHz ref_clk; registers reached over a plain strobe port.
// Notes: Offsets are word indices on the plain register port.
package usbu_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int ADDR_W = 4;
  // Register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FMT = 4'h1;
  localparam logic [3:0] REG_BAUD = 4'h2;
  localparam logic [3:0] REG_TXDATA = 4'h3;
  localparam logic [3:0] REG_RXDATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  localparam logic [3:0] REG_IRQSTAT = 4'h6;
  localparam logic [3:0] REG_IRQEN = 4'h7;
  localparam logic [3:0] REG_IRQCLR = 4'h8;
  localparam logic [3:0] REG_MODEM = 4'h9;
  // Control bits.
  localparam int CTRL_CONFIGURED = 0;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_DTR = 2;
  localparam int CTRL_FLOW_LSB = 3;
  localparam int CTRL_RESUME = 5;
  // Format fields.
  localparam int FMT_BITS_LSB = 0;
  localparam int FMT_PAR_LSB = 2;
  localparam int FMT_STOP_LSB = 5;
  // Flow control modes.
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_RTSCTS = 2'h1;
  localparam logic [1:0] FLOW_DSRDTR = 2'h2;
  localparam logic [1:0] FLOW_XONXOFF = 2'h3;
  // Parity modes.
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;
  // Stop lengths.
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_ONEHALF = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  // Interrupt bits.
  localparam int IRQ_RXDONE = 0;
  localparam int IRQ_TXDONE = 1;
  localparam int IRQ_RXERR = 2;
  localparam int IRQ_SUSP = 3;
  localparam int IRQ_W = 4;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam int unsigned BAUD_MIN = 300;
  localparam int unsigned BAUD_MAX = 921600;
  localparam logic [23:0] BAUD_RESET = 24'h01c200;
  // Oversampling: one tick per half bit, so 1.5 stop bits are exact.
  localparam int unsigned HALF_PER_BIT = 2;
  // Half-bit period in clocks for a given baud.
  function automatic logic [19:0] half_div(input logic [23:0] baud);
    logic [31:0] q;
    q = CLK_HZ / (HALF_PER_BIT * {8'h00, baud});
    return q[19:0];
  endfunction : half_div
endpackage : usbu_pkg

// >>> design/usbu_tick_if.sv
// Purpose: Carries half-bit tick and line format between core and framer.
// Assumes: One clock domain.
// Notes: Driven by the core, read by the framer.
interface usbu_tick_if;
  logic tick;
  logic [1:0] dataBits;
  logic [2:0] parity;
  logic [1:0] stopLen;
  modport src (output tick, output dataBits, output parity, output stopLen);
  modport dst (input tick, input dataBits, input parity, input stopLen);
endinterface : usbu_tick_if

// >>> design/usbu_tx.sv
// Purpose: Serial transmit framer working on half-bit ticks.
// Assumes: tick is a one-cycle pulse at twice the baud rate.
// Notes: Line idles high; start, data LSB first, parity, stops.
module usbu_tx
  import usbu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  usbu_tick_if.dst cfg,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic done,
  output logic txLine
);
  logic [11:0] shift_r;
  logic [4:0] halves_r;
  logic ph_r;

  function automatic logic par_bit(input logic [7:0] d, input logic [2:0] p, input logic [1:0] nb);
    logic [7:0] m;
    m = 8'hff >> (2'd3 - nb);
    case (p)
      PAR_ODD: return ~^(d & m);
      PAR_EVEN: return ^(d & m);
      PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : par_bit

  // Build data, parity and stop bits into a shift register, drive the start bit directly, then walk it per bit.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= '1;
      halves_r <= '0;
      ph_r <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      txLine <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        logic [3:0] nb;
        logic [11:0] f;
        nb = 4'd5 + {2'b00, cfg.dataBits};
        // Unused data bits are forced high, or they would cut into the stop bits.
        f = ({4'h0, data} & {4'h0, 8'hff >> (4'd8 - nb)}) | ({12{1'b1}} << nb);
        if (cfg.parity != PAR_NONE) begin
          f[nb] = par_bit(data, cfg.parity, cfg.dataBits);
          nb = nb + 4'd1;
        end
        shift_r <= f;
        // Halves: start + data/parity at 2 each, then 2, 3 or 4 stop halves.
        halves_r <= 5'(2 + 2 * nb + (cfg.stopLen == STOP_TWO ? 4 :
                    (cfg.stopLen == STOP_ONEHALF ? 3 : 2)));
        txLine <= 1'b0;
        ph_r <= 1'b0;
        busy <= 1'b1;
      end else if (busy && cfg.tick) begin
        ph_r <= ~ph_r;
        if (halves_r == 5'd1) begin
          busy <= 1'b0;
          done <= 1'b1;
          txLine <= 1'b1;
        end else if (ph_r) begin
          txLine <= shift_r[0];
          shift_r <= {1'b1, shift_r[11:1]};
        end
        halves_r <= halves_r - 5'd1;
      end
    end
  end
endmodule : usbu_tx

// >>> design/usbu_bridge.sv
// Purpose: USB serial bridge core: suspend indicators, modem lines, UART.
// Assumes: USB front end reports bus events on the usbSuspendDet, usbResumeDet and usbBusReset inputs; serial pins are asynchronous.
// Notes: Suspend indicators also assert while the host has not configured the device.
// Function
// - Carry USB data to the serial port and obey host control requests.
// - Enter suspend whenever USB suspend signalling is detected.
// - Entering suspend asserts both suspend indicators.
// - One indicator is high, the other low, while suspended.
// - After device reset indicators stay asserted until configuration completes.
// - Leave suspend on resume, USB bus reset, or device reset.
// - Leaving suspend deasserts both suspend indicators; here they stay asserted after a USB bus reset until configured again.
// - During device reset both indicators are released and float high.
// - Provide TX, RX and RTS, CTS, DSR, DTR, DCD, RI lines.
// - Modem lines are active low; RTS, DTR out, others in.
// - Select RTS/CTS, DSR/DTR or X-On/X-Off flow control.
// - Format and baud come from host configuration requests only.
// - Support 5 to 8 data bits; 921600 only with 7 or 8.
// - Parity none, even, odd, mark or space.
// - Baud rates from 300 to 921600 including 115200 and 230400.
//
// The register addresses and the address-and-strobe port were left to the implementer.
module usbu_bridge
  import usbu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic usbSuspendDet,
  input wire logic usbResumeDet,
  input wire logic usbBusReset,
  output logic suspendHi,
  output logic suspendHiOe_n,
  output logic suspendLo_n,
  output logic suspendLoOe_n,
  output logic txd,
  input wire logic rxd,
  output logic rts_n,
  input wire logic cts_n,
  output logic dtr_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: first stage feeds only the second.
  logic [4:0] pinMeta_r;
  logic [4:0] pinSync_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_r <= '1;
      pinSync_r <= '1;
    end else begin
      pinMeta_r <= {rxd, cts_n, dsr_n, dcd_n, ri_n};
      pinSync_r <= pinMeta_r;
    end
  end
  logic rxS, ctsS_n, dsrS_n;
  assign rxS = pinSync_r[4];
  assign ctsS_n = pinSync_r[3];
  assign dsrS_n = pinSync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers written by host requests.
  logic configured_r, rtsReq_r, dtrReq_r;
  logic [1:0] flow_r;
  logic [1:0] dataBits_r;
  logic [2:0] parity_r;
  logic [1:0] stopLen_r;
  logic [23:0] baud_r;
  logic [19:0] halfDiv_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      configured_r <= 1'b0;
      rtsReq_r <= 1'b0;
      dtrReq_r <= 1'b0;
      flow_r <= FLOW_NONE;
      dataBits_r <= 2'h3;
      parity_r <= PAR_NONE;
      stopLen_r <= STOP_ONE;
      baud_r <= BAUD_RESET;
      halfDiv_r <= half_div(BAUD_RESET);
    end else if (usbBusReset) begin
      configured_r <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        REG_CTRL: begin
          configured_r <= regWdata[CTRL_CONFIGURED];
          rtsReq_r <= regWdata[CTRL_RTS];
          dtrReq_r <= regWdata[CTRL_DTR];
          flow_r <= regWdata[CTRL_FLOW_LSB +: 2];
        end
        REG_FMT: begin
          // Illegal combinations are refused and the old format kept.
          if (regWdata[FMT_PAR_LSB +: 3] <= PAR_SPACE && regWdata[FMT_STOP_LSB +: 2] != 2'h3 &&
              (regWdata[FMT_STOP_LSB +: 2] != STOP_ONEHALF || regWdata[FMT_BITS_LSB +: 2] == 2'h0) &&
              (baud_r != BAUD_MAX[23:0] || regWdata[FMT_BITS_LSB + 1])) begin
            dataBits_r <= regWdata[FMT_BITS_LSB +: 2];
            parity_r <= regWdata[FMT_PAR_LSB +: 3];
            stopLen_r <= regWdata[FMT_STOP_LSB +: 2];
          end
        end
        REG_BAUD: begin
          if (regWdata[23:0] >= BAUD_MIN[23:0] && regWdata[23:0] <= BAUD_MAX[23:0] &&
              (regWdata[23:0] != BAUD_MAX[23:0] || dataBits_r[1])) begin
            baud_r <= regWdata[23:0];
            halfDiv_r <= half_div(regWdata[23:0]);
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Suspend state and indicators.
  logic suspended_r;
  logic resumeReq;
  assign resumeReq = regWr && regAddr == REG_CTRL && regWdata[CTRL_RESUME];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      suspended_r <= 1'b0;
    end else if (usbResumeDet || usbBusReset || resumeReq) begin
      suspended_r <= 1'b0;
    end else if (usbSuspendDet) begin
      suspended_r <= 1'b1;
    end
  end
  // Pins are released in reset so the board pulls set the level.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      suspendHi <= 1'b1;
      suspendLo_n <= 1'b1;
      suspendHiOe_n <= 1'b1;
      suspendLoOe_n <= 1'b1;
    end else begin
      suspendHiOe_n <= 1'b0;
      suspendLoOe_n <= 1'b0;
      suspendHi <= suspended_r || !configured_r;
      suspendLo_n <= !(suspended_r || !configured_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-bit tick divider.
  usbu_tick_if tif ();
  logic [19:0] divCnt_r;
  logic tick_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_r <= '0;
      tick_r <= 1'b0;
    end else if (divCnt_r + 20'd1 >= halfDiv_r) begin
      divCnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 20'd1;
      tick_r <= 1'b0;
    end
  end
  assign tif.tick = tick_r;
  assign tif.dataBits = dataBits_r;
  assign tif.parity = parity_r;
  assign tif.stopLen = stopLen_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path with flow control gating.
  logic [7:0] txHold_r;
  logic txFull_r, txBusy, txDone, txLine;
  logic xoffSeen_r, sendXoff_r, sendXon_r, ctlInFlight_r;
  logic peerReady, txStart;
  logic [7:0] txByte;
  always_comb begin
    case (flow_r)
      FLOW_RTSCTS: peerReady = !ctsS_n;
      FLOW_DSRDTR: peerReady = !dsrS_n;
      FLOW_XONXOFF: peerReady = !xoffSeen_r;
      default: peerReady = 1'b1;
    endcase
  end
  assign txStart = !txBusy && (sendXoff_r || sendXon_r || (txFull_r && peerReady));
  assign txByte = sendXoff_r ? XOFF_CHAR : (sendXon_r ? XON_CHAR : txHold_r);

  usbu_tx i_usbu_tx (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cfg(tif.dst),
    .start(txStart),
    .data(txByte),
    .busy(txBusy),
    .done(txDone),
    .txLine(txLine)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txd <= 1'b1;
    end else begin
      txd <= txLine;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: the start edge is seen up to half a bit late, so sampling one tick later lands in each bit.
  logic [7:0] rxShift_r, rxData_r;
  logic rxFull_r, rxActive_r, rxHalf_r, rxErr;
  logic [3:0] rxIdx_r;
  logic rxDone;
  logic [3:0] rxBitsTotal;
  assign rxBitsTotal = 4'd5 + {2'b00, dataBits_r} + {3'b000, parity_r != PAR_NONE};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxActive_r <= 1'b0;
      rxHalf_r <= 1'b0;
      rxIdx_r <= '0;
      rxShift_r <= '0;
    end else if (!rxActive_r) begin
      if (!rxS && tick_r) begin
        rxActive_r <= 1'b1;
        rxHalf_r <= 1'b0;
        rxIdx_r <= '0;
      end
    end else if (tick_r) begin
      rxHalf_r <= ~rxHalf_r;
      if (!rxHalf_r) begin
        if (rxIdx_r == 4'd0 && rxS) begin
          rxActive_r <= 1'b0;
        end else if (rxIdx_r > rxBitsTotal) begin
          rxActive_r <= 1'b0;
        end else if (rxIdx_r != 4'd0 && rxIdx_r <= 4'd8) begin
          rxShift_r[rxIdx_r[2:0] - 3'd1] <= rxS;
        end
        rxIdx_r <= rxIdx_r + 4'd1;
      end
    end
  end
  assign rxDone = rxActive_r && tick_r && !rxHalf_r && rxIdx_r > rxBitsTotal;
  // Only the first stop bit is checked; parity is received but not checked.
  assign rxErr = rxDone && !rxS;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxData_r <= '0;
      rxFull_r <= 1'b0;
    end else if (rxDone) begin
      rxData_r <= rxShift_r & (8'hff >> (2'd3 - dataBits_r));
      rxFull_r <= 1'b1;
    end else if (regRd && regAddr == REG_RXDATA) begin
      rxFull_r <= 1'b0;
    end
  end

  // X-On/X-Off: track the peer's pause and pace the peer by our buffer.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      xoffSeen_r <= 1'b0;
      sendXoff_r <= 1'b0;
      sendXon_r <= 1'b0;
      ctlInFlight_r <= 1'b0;
    end else begin
      if (rxDone && flow_r == FLOW_XONXOFF && rxShift_r == XOFF_CHAR) xoffSeen_r <= 1'b1;
      else if (rxDone && rxShift_r == XON_CHAR) xoffSeen_r <= 1'b0;
      if (txStart && (sendXoff_r || sendXon_r)) begin
        sendXoff_r <= 1'b0;
        sendXon_r <= 1'b0;
        ctlInFlight_r <= 1'b1;
      end else if (flow_r == FLOW_XONXOFF && rxDone && !ctlInFlight_r) begin
        sendXoff_r <= 1'b1;
      end else if (flow_r == FLOW_XONXOFF && regRd && regAddr == REG_RXDATA && ctlInFlight_r) begin
        sendXon_r <= 1'b1;
        ctlInFlight_r <= 1'b0;
      end
    end
  end

  // Holding register written from USB data; a write while full is dropped.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txHold_r <= '0;
      txFull_r <= 1'b0;
    end else if (regWr && regAddr == REG_TXDATA && !txFull_r) begin
      txHold_r <= regWdata[7:0];
      txFull_r <= 1'b1;
    end else if (txStart && !sendXoff_r && !sendXon_r) begin
      txFull_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem outputs: asserted low, RTS also signals receive space.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      rts_n <= !(flow_r == FLOW_RTSCTS ? !rxFull_r : rtsReq_r);
      dtr_n <= !(flow_r == FLOW_DSRDTR ? !rxFull_r : dtrReq_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over clear.
  logic [IRQ_W-1:0] irqStat_r, irqEn_r, irqEv;
  assign irqEv = {usbSuspendDet && !suspended_r, rxErr, txDone, rxDone};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqStat_r <= '0;
      irqEn_r <= '0;
    end else begin
      if (regWr && regAddr == REG_IRQEN) irqEn_r <= regWdata[IRQ_W-1:0];
      irqStat_r <= (irqStat_r & ~((regWr && regAddr == REG_IRQCLR) ? regWdata[IRQ_W-1:0] : '0)) | irqEv;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) irq <= 1'b0;
    else irq <= |(irqStat_r & irqEn_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, zero otherwise.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL: regRdata <= {26'h0, 1'b0, flow_r, dtrReq_r, rtsReq_r, configured_r};
        REG_FMT: regRdata <= {25'h0, stopLen_r, parity_r, dataBits_r};
        REG_BAUD: regRdata <= {8'h00, baud_r};
        REG_RXDATA: regRdata <= {24'h0, rxData_r};
        REG_STAT: regRdata <= {26'h0, xoffSeen_r, suspended_r, txBusy, txFull_r, rxFull_r, 1'b0};
        REG_IRQSTAT: regRdata <= {28'h0, irqStat_r};
        REG_IRQEN: regRdata <= {28'h0, irqEn_r};
        REG_MODEM: regRdata <= {27'h0, pinSync_r[3:0], rts_n};
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  suspend_pol_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !suspendHiOe_n |-> suspendHi == !suspendLo_n) else $error("suspend outputs not complementary");
  suspend_enter_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    usbSuspendDet && !usbResumeDet && !usbBusReset && !resumeReq |-> ##2 suspendHi)
    else $error("suspend not indicated");
  suspend_exit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    usbResumeDet && configured_r && !usbBusReset |=> !suspended_r)
    else $error("resume did not leave suspend");
  unconfig_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !configured_r && !$past(configured_r) |-> ##1 suspendHi) else $error("indicator dropped early");
  bus_reset_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    usbBusReset |=> !suspended_r && !configured_r) else $error("bus reset ignored");
  tx_start_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    txStart |=> ##1 !txd) else $error("start bit not low");
  cts_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    flow_r == FLOW_RTSCTS && ctsS_n && !sendXoff_r && !sendXon_r |-> !txStart)
    else $error("sent while peer not clear");
  fmt_legal_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    stopLen_r == STOP_ONEHALF |-> dataBits_r == 2'h0) else $error("1.5 stop with wide char");
  fast_baud_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    baud_r == BAUD_MAX[23:0] |-> dataBits_r[1]) else $error("top rate with short char");
  baud_range_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    baud_r >= BAUD_MIN[23:0] && baud_r <= BAUD_MAX[23:0]) else $error("baud out of range");
endmodule : usbu_bridge

// >>> testbench/usbu_peer.sv
// Purpose: Serial peripheral model facing the bridge: frame monitor and sender.
// Assumes: The line idles high through a pull-up; bitCyc is set by the bench.
// Notes: Each transmitted bit is sampled in its middle, twelve samples a frame.
module usbu_peer (
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n,
  output logic dsr_n,
  output logic dcd_n,
  output logic ri_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitCyc = 270;
  int nFrames = 0;
  logic [11:0] frame = 12'hfff;
  initial begin
    rxd = 1'b1;
    {ri_n, dcd_n, dsr_n, cts_n} = 4'hf;
  end
  ////////////////////////////////////////
  // Samples past a short frame see the idle level, so they must read high.
  initial begin
    forever begin
      @(negedge txd);
      repeat (bitCyc / 2) @(posedge ref_clk);
      for (int i = 0; i < 12; i++) begin
        frame[i] = txd;
        if (i < 11) repeat (bitCyc) @(posedge ref_clk);
      end
      nFrames++;
    end
  end
  task automatic sendByte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      rxd <= f[i];
      repeat (bitCyc - 1) @(posedge ref_clk);
    end
  endtask : sendByte
  task automatic setModem(input logic [3:0] v);
    @(posedge ref_clk);
    {ri_n, dcd_n, dsr_n, cts_n} <= v;
  endtask : setModem
endmodule : usbu_peer

// >>> testbench/usbu_bridge_test.sv
// Purpose: Self-checking bench for the bridge core.
// Assumes: 250 MHz clock; register port with one-cycle strobes.
// Notes: Serial rates of 921600 and 460800 keep each frame short.
module usbu_bridge_test
  import usbu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic usbSuspendDet = 1'b0;
  logic usbResumeDet = 1'b0;
  logic usbBusReset = 1'b0;
  logic [31:0] regRdata;
  logic suspendHi, suspendHiOe_n, suspendLo_n, suspendLoOe_n, txd, rxd, rts_n, cts_n, dtr_n, dsr_n, dcd_n, ri_n, irq;
  logic [31:0] rv;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] fmtTab [5] = '{32'h03, 32'h4a, 32'h05, 32'h2c, 32'h53};
  logic [31:0] baudTab [5] = '{32'he1000, 32'he1000, 32'h70800, 32'h70800, 32'h70800};
  logic [7:0] dataTab [5] = '{8'ha5, 8'h5b, 8'h2c, 8'h13, 8'h80};
  usbu_bridge i_usbu_bridge (.ref_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .usbSuspendDet,
    .usbResumeDet, .usbBusReset, .suspendHi, .suspendHiOe_n, .suspendLo_n, .suspendLoOe_n, .txd, .rxd, .rts_n,
    .cts_n, .dtr_n, .dsr_n, .dcd_n, .ri_n, .irq);
  usbu_peer i_usbu_peer (.ref_clk, .txd, .rxd, .cts_n, .dsr_n, .dcd_n, .ri_n);
  initial forever #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic endTest(input string name);
    $display("test %s ended: %0d checks, %0d wrong", name, num_checks, n_errors);
  endtask : endTest
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask : rd
  task automatic usbEvt(input int k);
    @(posedge ref_clk);
    {usbBusReset, usbResumeDet, usbSuspendDet} <= 3'(1 << k);
    @(posedge ref_clk);
    {usbBusReset, usbResumeDet, usbSuspendDet} <= 3'h0;
    repeat (3) @(posedge ref_clk);
  endtask : usbEvt
  task automatic chkInd(input logic [3:0] e);
    chk({suspendHi, suspendHiOe_n, suspendLo_n, suspendLoOe_n}, e);
  endtask : chkInd
  task automatic waitFrames(input int n);
    for (int i = 0; i < 20000 && i_usbu_peer.nFrames < n; i++) @(posedge ref_clk);
    if (i_usbu_peer.nFrames < n) begin
      n_errors++;
      report_and_stop();
    end
  endtask : waitFrames
  function automatic logic [11:0] expFrame(input logic [31:0] f, input logic [7:0] d);
    int nb;
    logic [7:0] m;
    logic [11:0] e;
    nb = 5 + int'(f[1:0]);
    m = d & (8'hff >> (8 - nb));
    e = 12'hffe;
    for (int i = 0; i < nb; i++) e[1 + i] = m[i];
    case (f[4:2])
      PAR_ODD: e[1 + nb] = ~^m;
      PAR_EVEN: e[1 + nb] = ^m;
      PAR_SPACE: e[1 + nb] = 1'b0;
      default: ;
    endcase
    return e;
  endfunction : expFrame
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    chkInd(4'b1111);
    chk({txd, rts_n, dtr_n, irq}, 4'he);
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chkInd(4'b1000);
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk);
    chkInd(4'b0010);
    endTest("reset");
    wr(REG_IRQEN, 32'h8);
    for (int k = 0; k < 4; k++) begin
      usbEvt(0);
      chkInd(4'b1000);
      chk(irq, 1'b1);
      rd(REG_STAT, rv);
      chk(rv[4], 1'b1);
      if (k == 0) usbEvt(1);
      else if (k == 1) wr(REG_CTRL, 32'h21);
      else if (k == 2) usbEvt(2);
      else begin
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(negedge ref_clk);
        chkInd(4'b1111);
        @(posedge ref_clk);
        rstn <= 1'b1;
      end
      repeat (3) @(posedge ref_clk);
      rd(REG_STAT, rv);
      chk(rv[4], 1'b0);
      chkInd(k < 2 ? 4'b0010 : 4'b1000);
      wr(REG_IRQCLR, 32'hf);
      repeat (2) @(posedge ref_clk);
      chk(irq, 1'b0);
      wr(REG_CTRL, 32'h1);
    end
    // Enable was cleared by the device reset, so the event must stay masked.
    usbEvt(0);
    chk(irq, 1'b0);
    rd(REG_IRQSTAT, rv);
    chk(rv[3], 1'b1);
    wr(REG_IRQEN, 32'h8);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    wr(REG_IRQCLR, 32'h8);
    usbEvt(1);
    endTest("suspend");
    rd(4'hf, rv);
    chk(rv, 32'h0);
    wr(REG_BAUD, 32'he1000);
    wr(REG_FMT, 32'h03);
    wr(REG_FMT, 32'h00);
    wr(REG_FMT, 32'h23);
    wr(REG_FMT, 32'h17);
    rd(REG_FMT, rv);
    chk(rv, 32'h03);
    wr(REG_BAUD, 32'h12b);
    rd(REG_BAUD, rv);
    chk(rv, 32'he1000);
    wr(REG_BAUD, 32'h12c);
    rd(REG_BAUD, rv);
    chk(rv, 32'h12c);
    endTest("format");
    for (int t = 0; t < 5; t++) begin
      wr(REG_BAUD, baudTab[t]);
      wr(REG_FMT, fmtTab[t]);
      i_usbu_peer.bitCyc = 2 * (CLK_HZ / (2 * baudTab[t]));
      wr(REG_TXDATA, 32'(dataTab[t]));
      waitFrames(t + 1);
      chk(i_usbu_peer.frame, expFrame(fmtTab[t], dataTab[t]));
      repeat (i_usbu_peer.bitCyc) @(posedge ref_clk);
    end
    endTest("transmit");
    wr(REG_BAUD, 32'he1000);
    wr(REG_FMT, 32'h03);
    i_usbu_peer.bitCyc = 270;
    i_usbu_peer.sendByte(8'hc3);
    rv = 32'h0;
    for (int i = 0; i < 2000 && rv[1] !== 1'b1; i++) rd(REG_STAT, rv);
    chk(rv[1], 1'b1);
    rd(REG_RXDATA, rv);
    chk(rv[7:0], 8'hc3);
    endTest("receive");
    i_usbu_peer.setModem(4'he);
    wr(REG_CTRL, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk({rts_n, dtr_n}, 2'b00);
    rd(REG_MODEM, rv);
    chk(rv[4:0], 5'h0e);
    i_usbu_peer.setModem(4'hf);
    wr(REG_CTRL, 32'h9);
    wr(REG_TXDATA, 32'h5a);
    rv[0] = 1'b1;
    repeat (600) begin
      @(posedge ref_clk);
      rv[0] = rv[0] & txd;
    end
    chk(rv[0], 1'b1);
    chk(rts_n, 1'b0);
    i_usbu_peer.setModem(4'he);
    waitFrames(6);
    chk(i_usbu_peer.frame, expFrame(32'h03, 8'h5a));
    // DSR/DTR mode: DTR shows receive space, and DSR high holds the byte back.
    wr(REG_CTRL, 32'h11);
    wr(REG_TXDATA, 32'h3c);
    repeat (2) @(posedge ref_clk);
    chk({rts_n, dtr_n}, 2'b10);
    rd(REG_STAT, rv);
    chk(rv[3:2], 2'b01);
    endTest("modem");
    report_and_stop();
  end
endmodule : usbu_bridge_test
